// ### logic/clock_control_consts.svh
`ifndef CLOCK_CONTROL_CONSTS_SVH
`define CLOCK_CONTROL_CONSTS_SVH
// ----------------------------------------
// register addresses and layouts
// ----------------------------------------
`define CC_MISC_ADDR 32'h40028000
`define CC_DIV_ADDR 32'h40028004
`define CC_IRQ_STATUS_ADDR 32'h40028020
`define CC_IRQ_MASK_ADDR 32'h40028024
`define CC_MISC_RESET 16'h0041
`define CC_DIV_RESET 16'h0200
`define CC_MISC_WMASK 16'heff3
`define CC_DIV_WMASK 16'h0707
`define CC_IRQ_WMASK 16'h0007
`define CC_CRYSTAL_IE_BIT 15
`define CC_PLL_IE_BIT 13
`define CC_PLL_REF_BIT 11
`define CC_CLOCK_OUTPUT_SELECT_LSB 4
`define CC_ROOT_LSB 0
`define CC_PERIPH_LSB 8
`define CC_BUS_LSB 0
`define CC_IRQ_CRYSTAL_OK_BIT 0
`define CC_IRQ_CRYSTAL_NOK_BIT 1
`define CC_IRQ_PLL_BIT 2
// ----------------------------------------
// field codes
// ----------------------------------------
`define CC_ROOT_INTERNAL 2'h0
`define CC_ROOT_PLL 2'h1
`define CC_ROOT_RESERVED 2'h2
`define CC_ROOT_EXT_PIN 2'h3
`define CC_OUT_ROOT 4'h0
`define CC_OUT_LOW_POWER 4'h1
`define CC_OUT_INTERNAL 4'h2
`define CC_OUT_CORE 4'h4
`define CC_OUT_PERIPH 4'h5
`define CC_OUT_TIMER0 4'hb
`define CC_OUT_WAKEUP 4'hc
`define CC_OUT_CRYSTAL 4'he
`define CC_PERIPH_DIVIDE_BY_FOUR 3'h2
`define CC_PERIPH_DIV16 3'h4
`define CC_PERIPH_DIVIDE_BY_MAX 3'h7
`define CC_PERIPH_RESET_EXP 3'h2
`define CC_BUS_RESET_EXP 3'h0
`endif

// ### logic/clock_control_pkg.sv
package clock_control_pkg;
  typedef enum logic [2:0] {
    SEL_RUN = 3'b001,
    SEL_DRAIN = 3'b010,
    SEL_ENTER = 3'b100
  } selState_e;
  typedef struct packed {
    logic internalOsc;
    logic pllOut;
    logic extPin;
    logic lowPowerOsc;
    logic crystalOsc;
    logic timer0Clk;
    logic wakeupClk;
    logic crystalOk;
    logic pllLocked;
  } clockSources_s;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [31:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wbRequest_s;
  typedef struct packed {
    logic [15:0] misc;
    logic [15:0] div;
    logic [2:0] irqStatus;
    logic [2:0] irqMask;
    selState_e selState;
    logic [1:0] activeRoot;
    logic [1:0] pendingRoot;
    logic rootClk;
    logic clockOut;
    logic pllReference;
    logic irq;
    logic ack;
    logic [31:0] datRd;
    logic crystalOkSeen;
    logic pllLockedSeen;
    logic [2:0] periphExp;
  } ctrlState_s;
  typedef struct packed {
    logic [6:0] count;
    logic [2:0] exp;
    logic srcPrev;
    logic divClk;
  } divState_s;
  typedef struct packed {
    clockSources_s stage1;
    clockSources_s stage2;
  } syncState_s;
endpackage

// ### logic/source_sync.sv
`timescale 1ns/100ps
module source_sync
  import clock_control_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input clockSources_s raw,
  output clockSources_s synced
);
  syncState_s state;
  syncState_s next_state;
  // ----------------------------------------
  // two stages; stage1 feeds stage2 only
  // ----------------------------------------
  always_comb begin
    next_state.stage1 = raw;
    next_state.stage2 = state.stage1;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
  assign synced = state.stage2;
endmodule

// ### logic/power2_divider.sv
`timescale 1ns/100ps
module power2_divider
  import clock_control_pkg::*;
#(
  parameter logic [2:0] RESET_EXP = 3'h0
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic src,
  input wire logic [2:0] exp,
  output logic divClk
);
  divState_s state;
  divState_s next_state;
  logic rise;
  logic [6:0] countNext;
  // ----------------------------------------
  // divide by two to the power exp
  // ----------------------------------------
  always_comb begin
    next_state = state;
    rise = src & ~state.srcPrev;
    countNext = rise ? state.count + 7'h01 : state.count;
    next_state.srcPrev = src;
    next_state.count = countNext;
    // new ratio only when every stage wraps low together, so no runt
    if (rise && state.count == 7'h7f) begin
      next_state.exp = exp;
    end
    if (state.exp == 3'h0) begin
      next_state.divClk = src;
    end else begin
      next_state.divClk = countNext[state.exp - 3'h1];
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= '{count: 7'h00, exp: RESET_EXP, srcPrev: 1'b0, divClk: 1'b0};
    end else begin
      state <= next_state;
    end
  end
  assign divClk = state.divClk;
endmodule

// ### logic/system_clock_select_divide.sv
// The Wishbone register port was decided locally.
`timescale 1ns/100ps
`include "clock_control_consts.svh"
module system_clock_select_divide
  import clock_control_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wbRequest_s wbReq,
  output logic [31:0] wbDatRd,
  output logic wbAck,
  input clockSources_s sources,
  output logic rootClk,
  output logic busClk,
  output logic periphClk,
  output logic dieLinkClk,
  output logic clockOut,
  output logic pllReference,
  output logic pllRefSelect,
  output logic irq
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // level of a root source; reserved code reads low
  function automatic logic rootLevel(
    input logic [1:0] code,
    input clockSources_s src
  );
    logic level;
    level = 1'b0;
    unique case (code)
      `CC_ROOT_INTERNAL: begin
        level = src.internalOsc;
      end
      `CC_ROOT_PLL: begin
        level = src.pllOut;
      end
      `CC_ROOT_EXT_PIN: begin
        level = src.extPin;
      end
      `CC_ROOT_RESERVED: begin
        level = 1'b0;
      end
    endcase
    return level;
  endfunction

  // byte-lane write limited to the writable bits
  function automatic logic [15:0] mergeWrite(
    input logic [15:0] old,
    input logic [31:0] data,
    input logic [3:0] sel,
    input logic [15:0] wmask
  );
    logic [15:0] lanes;
    lanes = {{8{sel[1]}}, {8{sel[0]}}} & wmask;
    return (old & ~lanes) | (data[15:0] & lanes);
  endfunction

  // peripheral code to exponent, with a valid flag
  function automatic logic [3:0] periphDecode(input logic [2:0] code);
    logic [3:0] result;
    result = 4'h0;
    if (code == `CC_PERIPH_DIVIDE_BY_FOUR) begin
      result = {1'b1, `CC_PERIPH_DIVIDE_BY_FOUR};
    end else if (code == `CC_PERIPH_DIV16) begin
      result = {1'b1, `CC_PERIPH_DIV16};
    end else if (code == `CC_PERIPH_DIVIDE_BY_MAX) begin
      result = {1'b1, `CC_PERIPH_DIVIDE_BY_MAX};
    end
    return result;
  endfunction

  ctrlState_s state;
  ctrlState_s next_state;
  clockSources_s syncSrc;
  logic busDiv;
  logic periphDiv;
  logic hit;
  logic isMisc;
  logic isDiv;
  logic isStatus;
  logic isMask;
  logic [2:0] events;
  logic [2:0] clearBits;
  logic [2:0] enableGate;
  logic [3:0] periphCode;
  logic [1:0] rootField;
  logic [3:0] outSel;
  logic activeLevel;
  logic pendingLevel;
  logic outLevel;

  localparam ctrlState_s RESET_STATE = '{
    misc: `CC_MISC_RESET,
    div: `CC_DIV_RESET,
    irqStatus: 3'h0,
    irqMask: 3'h0,
    selState: SEL_RUN,
    activeRoot: `CC_ROOT_PLL,
    pendingRoot: `CC_ROOT_PLL,
    rootClk: 1'b0,
    clockOut: 1'b0,
    pllReference: 1'b0,
    irq: 1'b0,
    ack: 1'b0,
    datRd: 32'h00000000,
    crystalOkSeen: 1'b0,
    pllLockedSeen: 1'b0,
    periphExp: `CC_PERIPH_RESET_EXP
  };

  // ----------------------------------------
  // pin sampling and dividers
  // ----------------------------------------
  source_sync sourceSync (
    .sys_clk(sys_clk),
    .rst(rst),
    .raw(sources),
    .synced(syncSrc)
  );

  power2_divider #(
    .RESET_EXP(`CC_BUS_RESET_EXP)
  ) busDivider (
    .sys_clk(sys_clk),
    .rst(rst),
    .src(state.rootClk),
    .exp(state.div[`CC_BUS_LSB +: 3]),
    .divClk(busDiv)
  );

  power2_divider #(
    .RESET_EXP(`CC_PERIPH_RESET_EXP)
  ) periphDivider (
    .sys_clk(sys_clk),
    .rst(rst),
    .src(state.rootClk),
    .exp(state.periphExp),
    .divClk(periphDiv)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_state = state;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    hit = wbReq.cyc & wbReq.stb & ~state.ack;
    isMisc = wbReq.adr == `CC_MISC_ADDR;
    isDiv = wbReq.adr == `CC_DIV_ADDR;
    isStatus = wbReq.adr == `CC_IRQ_STATUS_ADDR;
    isMask = wbReq.adr == `CC_IRQ_MASK_ADDR;
    next_state.ack = hit;
    clearBits = 3'h0;

    if (hit && wbReq.we) begin
      if (isMisc) begin
        next_state.misc = mergeWrite(state.misc, wbReq.dat, wbReq.sel, `CC_MISC_WMASK);
      end
      if (isDiv) begin
        // die link bit and reserved bits never take a write
        next_state.div = mergeWrite(state.div, wbReq.dat, wbReq.sel, `CC_DIV_WMASK);
      end
      if (isStatus) begin
        clearBits = wbReq.dat[2:0] & {3{wbReq.sel[0]}};
      end
      if (isMask) begin
        next_state.irqMask = wbReq.dat[2:0] & {3{wbReq.sel[0]}} | state.irqMask & ~{3{wbReq.sel[0]}};
      end
    end

    if (hit && !wbReq.we) begin
      if (isMisc) begin
        next_state.datRd = {16'h0000, state.misc & `CC_MISC_WMASK};
      end else if (isDiv) begin
        next_state.datRd = {16'h0000, state.div & `CC_DIV_WMASK};
      end else if (isStatus) begin
        next_state.datRd = {29'h0, state.irqStatus};
      end else if (isMask) begin
        next_state.datRd = {29'h0, state.irqMask};
      end else begin
        next_state.datRd = 32'h00000000;
      end
    end else if (hit) begin
      // write cycles return zero rather than stale data
      next_state.datRd = 32'h00000000;
    end

    // ----------------------------------------
    // events from the analog status levels
    // ----------------------------------------
    next_state.crystalOkSeen = syncSrc.crystalOk;
    next_state.pllLockedSeen = syncSrc.pllLocked;
    events = 3'h0;
    events[`CC_IRQ_CRYSTAL_OK_BIT] = syncSrc.crystalOk & ~state.crystalOkSeen;
    events[`CC_IRQ_CRYSTAL_NOK_BIT] = ~syncSrc.crystalOk & state.crystalOkSeen;
    events[`CC_IRQ_PLL_BIT] = syncSrc.pllLocked & ~state.pllLockedSeen;
    // a new event beats a clear in the same cycle
    next_state.irqStatus = (state.irqStatus & ~clearBits) | events;

    enableGate = 3'h0;
    enableGate[`CC_IRQ_CRYSTAL_OK_BIT] = state.misc[`CC_CRYSTAL_IE_BIT];
    enableGate[`CC_IRQ_CRYSTAL_NOK_BIT] = state.misc[`CC_CRYSTAL_IE_BIT];
    enableGate[`CC_IRQ_PLL_BIT] = state.misc[`CC_PLL_IE_BIT];
    // status records every event; mask and enable only gate the line
    next_state.irq = |(next_state.irqStatus & state.irqMask & enableGate);

    // ----------------------------------------
    // peripheral ratio; undefined codes leave the running ratio alone
    // ----------------------------------------
    periphCode = periphDecode(state.div[`CC_PERIPH_LSB +: 3]);
    if (periphCode[3]) begin
      next_state.periphExp = periphCode[2:0];
    end else begin
      next_state.periphExp = state.periphExp;
    end

    // ----------------------------------------
    // pll reference mux
    // ----------------------------------------
    // sampled levels, so the reference is only as clean as the sync flops
    if (state.misc[`CC_PLL_REF_BIT]) begin
      next_state.pllReference = syncSrc.crystalOsc;
    end else begin
      next_state.pllReference = syncSrc.internalOsc;
    end

    // ----------------------------------------
    // root clock switch: old source drains low, new joins while low
    // ----------------------------------------
    rootField = state.misc[`CC_ROOT_LSB +: 2];
    activeLevel = rootLevel(state.activeRoot, syncSrc);
    pendingLevel = rootLevel(state.pendingRoot, syncSrc);
    next_state.rootClk = activeLevel;
    unique case (state.selState)
      SEL_RUN: begin
        // reserved code is not followed; the old source keeps running
        if (rootField != `CC_ROOT_RESERVED && rootField != state.activeRoot) begin
          next_state.pendingRoot = rootField;
          next_state.selState = SEL_DRAIN;
        end
      end
      SEL_DRAIN: begin
        if (!activeLevel) begin
          next_state.rootClk = 1'b0;
          next_state.selState = SEL_ENTER;
        end
      end
      SEL_ENTER: begin
        next_state.rootClk = 1'b0;
        if (!pendingLevel) begin
          next_state.activeRoot = state.pendingRoot;
          next_state.selState = SEL_RUN;
        end
      end
      default: begin
        next_state.selState = SEL_RUN;
      end
    endcase

    // ----------------------------------------
    // gpio clock output; reserved codes hold it low
    // ----------------------------------------
    outSel = state.misc[`CC_CLOCK_OUTPUT_SELECT_LSB +: 4];
    unique case (outSel)
      `CC_OUT_ROOT: begin
        outLevel = state.rootClk;
      end
      `CC_OUT_LOW_POWER: begin
        outLevel = syncSrc.lowPowerOsc;
      end
      `CC_OUT_INTERNAL: begin
        outLevel = syncSrc.internalOsc;
      end
      `CC_OUT_CORE: begin
        outLevel = busDiv;
      end
      `CC_OUT_PERIPH: begin
        outLevel = periphDiv;
      end
      `CC_OUT_TIMER0: begin
        outLevel = syncSrc.timer0Clk;
      end
      `CC_OUT_WAKEUP: begin
        outLevel = syncSrc.wakeupClk;
      end
      `CC_OUT_CRYSTAL: begin
        outLevel = syncSrc.crystalOsc;
      end
      default: begin
        outLevel = 1'b0;
      end
    endcase
    next_state.clockOut = outLevel;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= RESET_STATE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // outputs, all from flops
  // ----------------------------------------
  assign wbDatRd = state.datRd;
  assign wbAck = state.ack;
  assign rootClk = state.rootClk;
  assign busClk = busDiv;
  // die link ratio is fixed at one, so it shares the bus clock flop
  assign dieLinkClk = busDiv;
  assign periphClk = periphDiv;
  assign clockOut = state.clockOut;
  assign pllReference = state.pllReference;
  assign pllRefSelect = state.misc[`CC_PLL_REF_BIT];
  assign irq = state.irq;
endmodule

// ### verif/clock_control_assertions.sv
`timescale 1ns/100ps
// ------
// port checks
// ------
module clock_control_assertions
  import clock_control_pkg::*;
(
  input logic sys_clk,
  input logic rst,
  input wbRequest_s wbReq,
  input logic [31:0] wbDatRd,
  input logic wbAck,
  input clockSources_s sources,
  input logic rootClk,
  input logic busClk,
  input logic periphClk,
  input logic dieLinkClk,
  input logic clockOut,
  input logic pllReference,
  input logic pllRefSelect,
  input logic irq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  logic req;
  logic rdReq;
  assign req = wbReq.cyc && wbReq.stb && !wbAck;
  assign rdReq = req && !wbReq.we;
  property p_ack_once;
    wbAck |=> !wbAck;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");
  property p_ack_answer;
    req |=> wbAck;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not answered");
  property p_ack_cause;
    wbAck |-> $past(req);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_die_link;
    dieLinkClk == busClk;
  endproperty
  a_die_link: assert property (p_die_link) else $error("die link clock differs");
  property p_ref_xtal;
    (pllRefSelect && sources.crystalOsc) [*4] |-> pllReference;
  endproperty
  a_ref_xtal: assert property (p_ref_xtal) else $error("crystal not routed");
  property p_ref_int;
    (!pllRefSelect && !sources.internalOsc) [*4] |-> !pllReference;
  endproperty
  a_ref_int: assert property (p_ref_int) else $error("internal osc not routed");
  property p_unmapped;
    rdReq && wbReq.adr == 32'h40028010 |=> wbDatRd == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_div_rsvd;
    rdReq && wbReq.adr == 32'h40028004 |=> (wbDatRd & 32'hfffff8f8) == 32'h0;
  endproperty
  a_div_rsvd: assert property (p_div_rsvd) else $error("divider reserved bits set");
  property p_misc_rsvd;
    rdReq && wbReq.adr == 32'h40028000 |=> (wbDatRd & 32'hffff100c) == 32'h0;
  endproperty
  a_misc_rsvd: assert property (p_misc_rsvd) else $error("misc read-only bits set");
  c_write: cover property (req && wbReq.we);
  c_irq: cover property ($rose(irq));
  c_ref: cover property ($rose(pllRefSelect));
endmodule
bind system_clock_select_divide clock_control_assertions chk_i (.sys_clk(sys_clk), .rst(rst), .wbReq(wbReq),
  .wbDatRd(wbDatRd), .wbAck(wbAck), .sources(sources), .rootClk(rootClk), .busClk(busClk), .periphClk(periphClk),
  .dieLinkClk(dieLinkClk), .clockOut(clockOut), .pllReference(pllReference), .pllRefSelect(pllRefSelect),
  .irq(irq));

// ### verif/testbench.sv
`timescale 1ns/100ps
`include "clock_control_consts.svh"
module testbench;
  import clock_control_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  wbRequest_s wbReq = '0;
  clockSources_s sources = '0;
  logic [31:0] wbDatRd;
  logic wbAck, rootClk, busClk, periphClk, dieLinkClk, clockOut, pllReference, pllRefSelect, irq;
  int err_count = 0;
  int check_count = 0;
  int cycles = 0;
  logic [7:0] lfsr = 8'h3d;
  logic sqOn = 1'b0;
  logic [31:0] rd;
  logic bPrev, pPrev, oPrev;
  int misc, act, bEdge, pEdge, oEdge, pExp;
  int rc[8] = '{1, 0, 0, 1, 3, 2, 0, 0}; // ext pin taken as set up for clock input
  int rf[8] = '{0, 0, 1, 1, 1, 1, 1, 0}; // reference moves only under the internal root
  int oc[8] = '{0, 1, 2, 4, 11, 12, 14, 2}; // defined codes only
  int bc[4] = '{0, 3, 6, 7};
  int pc[4] = '{2, 4, 7, 3};
  system_clock_select_divide uut (.sys_clk(sys_clk), .rst(rst), .wbReq(wbReq), .wbDatRd(wbDatRd), .wbAck(wbAck),
    .sources(sources), .rootClk(rootClk), .busClk(busClk), .periphClk(periphClk), .dieLinkClk(dieLinkClk),
    .clockOut(clockOut), .pllReference(pllReference), .pllRefSelect(pllRefSelect), .irq(irq));
  always #10 sys_clk = ~sys_clk;
  // ------
  // model and helpers
  // ------
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    // period of 4 cycles keeps the sampled pll wave clean
    if (sqOn && cycles[0]) sources.pllOut <= ~sources.pllOut;
    if (cycles == 20000) begin
      err_count++;
      wrap_up();
    end
  end
  function automatic logic [7:0] nxt(logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic logic selRoot(int c, clockSources_s s);
    return c == 0 ? s.internalOsc : c == 1 ? s.pllOut : s.extPin;
  endfunction
  function automatic logic selOut(int c, logic r, clockSources_s s);
    case (c)
      0, 4: return r; // core equals root only while bus divider is 1
      1: return s.lowPowerOsc;
      2: return s.internalOsc;
      11: return s.timer0Clk;
      12: return s.wakeupClk;
      14: return s.crystalOsc;
      default: return 1'b0;
    endcase
  endfunction
  // window phase may cost one edge
  function automatic int near(int g, int e);
    return (g - e <= 1 && e - g <= 1) ? e : g;
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // every clock source toggles in phase so a switch can finish
  task automatic keepRunning();
    repeat (6) begin
      sources <= clockSources_s'(9'h1fc);
      tick(2);
      sources <= '0;
      tick(2);
    end
  endtask
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wb(logic we, logic [31:0] adr, logic [15:0] dat);
    @(posedge sys_clk);
    wbReq <= '{1'b1, 1'b1, we, adr, 4'h3, {16'h0, dat}};
    @(posedge sys_clk);
    while (wbAck !== 1'b1) @(posedge sys_clk);
    rd = wbDatRd;
    wbReq <= '0;
  endtask
  task automatic rdchk(string nm, logic [31:0] adr, logic [31:0] exp);
    wb(1'b0, adr, 16'h0);
    chk(nm, exp, rd);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ------
  // scenarios
  // ------
  initial begin
    tick(3);
    rst <= 1'b0;
    rdchk("misc", `CC_MISC_ADDR, 32'h0041);
    rdchk("div", `CC_DIV_ADDR, 32'h0200);
    rdchk("status", `CC_IRQ_STATUS_ADDR, 32'h0);
    rdchk("mask", `CC_IRQ_MASK_ADDR, 32'h0);
    rdchk("unmapped", 32'h40028010, 32'h0);
    wb(1'b1, `CC_MISC_ADDR, 16'hf7ed);
    rdchk("miscMask", `CC_MISC_ADDR, 32'he7e1);
    $display("register test done");
    act = 1;
    for (int i = 0; i < 8; i++) begin
      misc = rf[i] << 11 | oc[i] << 4 | rc[i];
      wb(1'b1, `CC_MISC_ADDR, misc[15:0]);
      if (rc[i] != 2) act = rc[i];
      keepRunning();
      repeat (6) begin
        lfsr = nxt(lfsr);
        sources <= clockSources_s'({lfsr[6:0], 2'b00});
        tick(7);
        chk("rootClk", selRoot(act, sources), rootClk);
        chk("clockOut", selOut(oc[i], selRoot(act, sources), sources), clockOut);
        chk("pllRef", rf[i] ? sources.crystalOsc : sources.internalOsc, pllReference);
        chk("pllRefSelect", rf[i], pllRefSelect);
      end
      rdchk("misc", `CC_MISC_ADDR, misc);
    end
    $display("select test done");
    wb(1'b1, `CC_DIV_ADDR, 16'hffff);
    rdchk("divMask", `CC_DIV_ADDR, 32'h0707);
    wb(1'b1, `CC_MISC_ADDR, 16'h0051);
    keepRunning();
    sqOn <= 1'b1;
    pExp = 2;
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, `CC_DIV_ADDR, 16'(pc[i] << 8 | bc[i]));
      if (pc[i] inside {2, 4, 7}) pExp = pc[i];
      tick(700); // new ratio waits for the counter wrap
      bPrev = busClk;
      pPrev = periphClk;
      oPrev = clockOut;
      bEdge = 0;
      pEdge = 0;
      oEdge = 0;
      repeat (1024) begin
        @(posedge sys_clk);
        bEdge += int'(busClk && !bPrev);
        pEdge += int'(periphClk && !pPrev);
        oEdge += int'(clockOut && !oPrev);
        bPrev = busClk;
        pPrev = periphClk;
        oPrev = clockOut;
      end
      chk("clockOutPeriph", 256 >> pExp, near(oEdge, 256 >> pExp));
      chk("busEdges", 256 >> bc[i], near(bEdge, 256 >> bc[i]));
      chk("periphEdges", 256 >> pExp, near(pEdge, 256 >> pExp));
    end
    $display("divider test done");
    sqOn <= 1'b0;
    tick(1);
    sources <= '0;
    wb(1'b1, `CC_IRQ_MASK_ADDR, 16'h0007);
    sources.crystalOk <= 1'b1;
    tick(8);
    rdchk("status", `CC_IRQ_STATUS_ADDR, 32'h1);
    chk("irq", 1'b0, irq);
    wb(1'b1, `CC_MISC_ADDR, 16'h8001);
    tick(3);
    chk("irq", 1'b1, irq);
    sources.crystalOk <= 1'b0;
    tick(8);
    rdchk("status", `CC_IRQ_STATUS_ADDR, 32'h3);
    wb(1'b1, `CC_IRQ_STATUS_ADDR, 16'h0003);
    tick(3);
    chk("irq", 1'b0, irq);
    sources.pllLocked <= 1'b1;
    tick(8);
    chk("irq", 1'b0, irq);
    wb(1'b1, `CC_MISC_ADDR, 16'ha001);
    tick(3);
    chk("irq", 1'b1, irq);
    wb(1'b1, `CC_IRQ_MASK_ADDR, 16'h0003);
    tick(3);
    chk("irq", 1'b0, irq);
    wb(1'b1, `CC_IRQ_STATUS_ADDR, 16'h0004);
    rdchk("status", `CC_IRQ_STATUS_ADDR, 32'h0);
    $display("interrupt test done");
    wrap_up();
  end
endmodule
